// file: dac_ctrl_map.svh
`ifndef DAC_CTRL_MAP_SVH
`define DAC_CTRL_MAP_SVH

`define CLK_MHZ 10

`define MUTE_TC_US 3800
`define ATTACK_SHORT_US 6300
`define ATTACK_LONG_US 24300
`define RECOVERY_SHORT_US 12300000
`define RECOVERY_LONG_US 24600000
`define MUTE_STEPS 255

`define CMD_WIDTH 13
`define SEL_HI 12
`define SEL_LO 11
`define FIELD_HI 10
`define FIELD_LO 5
`define COEFF_HI 11

`define COEFF_UNITY 12'hfff
`define COEFF_SILENT 12'h000
`define COEFF_MIN 12'h001
`define ATTEN_RESET 12'h000
`define QUIET_LEVEL 16'sh0082

`define COMP_THR_MID 6'h18
`define COMP_THR_MAX 6'h24
`define COMP_RATIO_MID 5'h0c
`define COMP_RATIO_MAX 5'h12
`define FIX_BOOST_MID 8'h6a
`define FIX_BOOST_MAX 8'h98
`define GAIN_FULL 8'hff

`define REG_CTRL 8'h00
`define REG_ATTEN 8'h04
`define REG_MODE 8'h08
`define REG_STATE 8'h0c
`define CTRL_RESET 1'h1
`define CTRL_ENABLE_BIT 0

`endif

// file: dac_ctrl_pkg.sv
package dac_ctrl_pkg;

  typedef struct packed {
    logic deemph_enable;
    logic single_channel_select;
    logic channel_pick;
    logic chan_clock_polarity;
    logic compress_strength;
    logic dynamic_disable;
  } mode2_s;

  typedef struct packed {
    logic boost_mode_hi;
    logic boost_mode_lo;
    logic extra_boost;
    logic boost_path_mute;
    logic attack_select;
    logic recovery_select;
  } mode3_s;

  typedef enum logic [2:0] {
    BOOST_OFF,
    BOOST_MID,
    BOOST_MAX,
    BOOST_MAX_HIGH,
    BOOST_MEGA,
    BOOST_MEGA_HIGH
  } boost_e;

  typedef enum logic [1:0] {
    MUTE_IDLE,
    MUTE_RAMP,
    MUTE_HELD
  } mute_e;

endpackage

// file: serial_cmd_if.sv
interface serial_cmd_if;
  logic [12:0] word;
  logic        valid;
  modport rx  (output word, output valid);
  modport dec (input word, input valid);
endinterface

// file: serial_cmd_rx.sv
`include "dac_ctrl_map.svh"

module serial_cmd_rx (
  input logic       clk,
  input logic       rst_b,
  input logic       shift_pin,
  input logic       latch_pin,
  input logic       data_pin,
  serial_cmd_if.rx  cmd
);
  logic [2:0]            pins;
  logic [2:0]            level;
  logic [2:0]            level_d;
  logic [`CMD_WIDTH-1:0] sreg;
  logic                  shift_rise;
  logic                  latch_rise;

  assign pins = {latch_pin, data_pin, shift_pin};

  // a level only moves once the second and third stages agree
  for (genvar i = 0; i < 3; i++) begin : g_sync
    logic [2:0] chain;
    logic       held;
    always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
        chain <= 3'h0;
        held  <= 1'b0;
      end else begin
        chain <= {chain[1:0], pins[i]};
        if (chain[1] == chain[2]) begin
          held <= chain[2];
        end
      end
    end
    assign level[i] = held;
  end

  assign shift_rise = level[0] && !level_d[0];
  assign latch_rise = level[2] && !level_d[2];

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      level_d <= 3'h0;
    end else begin
      level_d <= level;
    end
  end

  // data and latch share the filter delay, so they line up with the shift edge
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sreg <= '0;
    end else if (shift_rise) begin
      sreg <= {sreg[`CMD_WIDTH-2:0], level[1]};
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cmd.word  <= '0;
      cmd.valid <= 1'b0;
    end else begin
      cmd.valid <= latch_rise;
      if (latch_rise) begin
        cmd.word <= sreg;
      end
    end
  end

endmodule // serial_cmd_rx

// file: audio_dac_serial_control_settings.sv
// Function
// - top bit low: word is attenuator, low twelve bits stored as coefficient
// - codes 001..ffe scale by code/4095; fff unity; 000 silences
// - minimum coefficient and input at or below -48 dB forces zero output
// - input below -(120 dB + attenuation) is lost
// - top bit high, next bit low: word is a mode 2 settings word
// - de-emphasis bit low bypasses filter, high inserts it
// - single channel off gives stereo; on, pick selects left or right
// - polarity low: channel clock low means right; high means left
// - strength low: -24 dB and 12 dB ratio; high: -36 dB and 18
// - dynamic disable low enables compressor, high disables it
// - extra boost high overrides dynamic disable
// - dynamic off: fixed boost 10.6 dB medium, 15.2 dB maximum
// - boost bits pick off/medium/max/max+high; extra boost raises each except off
// - mute bit rising ramps bass path mute over 3.8 ms; clear removes
// - attack time 6.3 ms when select low, 24.3 ms when high
// - recovery time 12.3 s when select low, 24.6 s when high
// - data sampled at each rising shift clock edge; word taken at rising latch edge
// - mode 3: both selectors high; bits 10..5 boost, extra, mute, times
// - mode 2: bits 10..5 de-emphasis, single_channel_select, pick, polarity, strength, disable
`include "dac_ctrl_map.svh"

module audio_dac_serial_control_settings #(
  parameter int unsigned MUTE_CYC     = `MUTE_TC_US * `CLK_MHZ,
  parameter int unsigned ATTACK_S_CYC = `ATTACK_SHORT_US * `CLK_MHZ,
  parameter int unsigned ATTACK_L_CYC = `ATTACK_LONG_US * `CLK_MHZ,
  parameter int unsigned RECOV_S_CYC  = `RECOVERY_SHORT_US * `CLK_MHZ,
  parameter int unsigned RECOV_L_CYC  = `RECOVERY_LONG_US * `CLK_MHZ
)(
  input  logic                 clk,
  input  logic                 rst_b,
  input  logic                 shift_pin,
  input  logic                 latch_pin,
  input  logic                 serial_data_in,
  input  logic                 channel_clock,
  input  logic signed [15:0]   sample_in,
  input  logic                 sample_strobe,
  input  logic                 psel,
  input  logic                 penable,
  input  logic                 pwrite,
  input  logic [7:0]           paddr,
  input  logic [31:0]          pwdata,
  output logic [31:0]          prdata,
  output logic                 pready,
  output logic                 pslverr,
  output logic signed [15:0]   left_out,
  output logic signed [15:0]   right_out,
  output logic                 out_valid,
  output logic                 deemph_enable,
  output logic [5:0]           comp_threshold_db,
  output logic [4:0]           comp_ratio_db,
  output logic                 dynamic_active,
  output dac_ctrl_pkg::boost_e boost_level,
  output logic                 high_boost,
  output logic [7:0]           fixed_boost_tenth_db,
  output logic [7:0]           boost_mute_gain,
  output logic [31:0]          attack_cycles,
  output logic [31:0]          recovery_cycles
);
  localparam int unsigned STEP_CYC =
    (MUTE_CYC / `MUTE_STEPS > 0) ? MUTE_CYC / `MUTE_STEPS : 1;

  serial_cmd_if cmd ();

  logic                 cmd_enable;
  logic [11:0]          atten_coeff;
  dac_ctrl_pkg::mode2_s m2;
  dac_ctrl_pkg::mode3_s m3;
  dac_ctrl_pkg::boost_e next_boost;
  logic [7:0]           next_fixed;
  logic                 next_dynamic;
  dac_ctrl_pkg::mute_e  mute_state;
  logic                 mute_prev;
  logic [31:0]          step_cnt;
  logic [2:0]           cc_chain;
  logic                 cc_level;
  logic signed [15:0]   left_raw;
  logic signed [15:0]   right_raw;
  logic signed [15:0]   route_l;
  logic signed [15:0]   route_r;
  logic                 strobe_d;
  logic [31:0]          rdata;
  logic                 rd_map;
  logic                 apb_take;

  serial_cmd_rx u_rx (
    .clk       (clk),
    .rst_b     (rst_b),
    .shift_pin (shift_pin),
    .latch_pin (latch_pin),
    .data_pin  (serial_data_in),
    .cmd       (cmd.rx)
  );

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      atten_coeff <= `ATTEN_RESET;
      m2          <= '0;
      m3          <= '0;
    end else if (cmd.valid && cmd_enable) begin
      if (!cmd.word[`SEL_HI]) begin
        atten_coeff <= cmd.word[`COEFF_HI:0];
      end else if (!cmd.word[`SEL_LO]) begin
        m2 <= dac_ctrl_pkg::mode2_s'(cmd.word[`FIELD_HI:`FIELD_LO]);
      end else begin
        m3 <= dac_ctrl_pkg::mode3_s'(cmd.word[`FIELD_HI:`FIELD_LO]);
      end
    end
  end

  always_comb begin
    next_dynamic = m3.extra_boost || !m2.dynamic_disable;
    case ({m3.boost_mode_hi, m3.boost_mode_lo})
      2'h0: next_boost = dac_ctrl_pkg::BOOST_OFF;
      2'h1: next_boost = m3.extra_boost ? dac_ctrl_pkg::BOOST_MAX : dac_ctrl_pkg::BOOST_MID;
      2'h2: next_boost = m3.extra_boost ? dac_ctrl_pkg::BOOST_MEGA : dac_ctrl_pkg::BOOST_MAX;
      2'h3: next_boost = m3.extra_boost ? dac_ctrl_pkg::BOOST_MEGA_HIGH
                                        : dac_ctrl_pkg::BOOST_MAX_HIGH;
      default: next_boost = dac_ctrl_pkg::BOOST_OFF;
    endcase
    next_fixed = 8'h00;
    if (!next_dynamic) begin
      case (next_boost)
        dac_ctrl_pkg::BOOST_MID:      next_fixed = `FIX_BOOST_MID;
        dac_ctrl_pkg::BOOST_MAX:      next_fixed = `FIX_BOOST_MAX;
        dac_ctrl_pkg::BOOST_MAX_HIGH: next_fixed = `FIX_BOOST_MAX;
        default:                      next_fixed = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      deemph_enable        <= 1'b0;
      comp_threshold_db    <= `COMP_THR_MID;
      comp_ratio_db        <= `COMP_RATIO_MID;
      dynamic_active       <= 1'b1;
      boost_level          <= dac_ctrl_pkg::BOOST_OFF;
      high_boost           <= 1'b0;
      fixed_boost_tenth_db <= 8'h00;
      attack_cycles        <= 32'h0;
      recovery_cycles      <= 32'h0;
    end else begin
      deemph_enable        <= m2.deemph_enable;
      comp_threshold_db    <= m2.compress_strength ? `COMP_THR_MAX : `COMP_THR_MID;
      comp_ratio_db        <= m2.compress_strength ? `COMP_RATIO_MAX : `COMP_RATIO_MID;
      dynamic_active       <= next_dynamic;
      boost_level          <= next_boost;
      high_boost           <= m3.boost_mode_hi && m3.boost_mode_lo;
      fixed_boost_tenth_db <= next_fixed;
      attack_cycles        <= m3.attack_select ? ATTACK_L_CYC : ATTACK_S_CYC;
      recovery_cycles      <= m3.recovery_select ? RECOV_L_CYC : RECOV_S_CYC;
    end
  end

  // linear ramp approximates the exponential mute; gain restores at once on clear
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      mute_state      <= dac_ctrl_pkg::MUTE_IDLE;
      mute_prev       <= 1'b0;
      step_cnt        <= 32'h0;
      boost_mute_gain <= `GAIN_FULL;
    end else begin
      mute_prev <= m3.boost_path_mute;
      case (mute_state)
        dac_ctrl_pkg::MUTE_IDLE: begin
          boost_mute_gain <= `GAIN_FULL;
          step_cnt        <= 32'h0;
          if (m3.boost_path_mute && !mute_prev) begin
            mute_state <= dac_ctrl_pkg::MUTE_RAMP;
          end
        end
        dac_ctrl_pkg::MUTE_RAMP: begin
          if (!m3.boost_path_mute) begin
            boost_mute_gain <= `GAIN_FULL;
            mute_state      <= dac_ctrl_pkg::MUTE_IDLE;
          end else if (step_cnt == STEP_CYC - 1) begin
            step_cnt        <= 32'h0;
            boost_mute_gain <= boost_mute_gain - 8'h01;
            if (boost_mute_gain == 8'h01) begin
              mute_state <= dac_ctrl_pkg::MUTE_HELD;
            end
          end else begin
            step_cnt <= step_cnt + 32'h1;
          end
        end
        dac_ctrl_pkg::MUTE_HELD: begin
          if (!m3.boost_path_mute) begin
            boost_mute_gain <= `GAIN_FULL;
            mute_state      <= dac_ctrl_pkg::MUTE_IDLE;
          end
        end
        default: mute_state <= dac_ctrl_pkg::MUTE_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cc_chain <= 3'h0;
      cc_level <= 1'b0;
    end else begin
      cc_chain <= {cc_chain[1:0], channel_clock};
      if (cc_chain[1] == cc_chain[2]) begin
        cc_level <= cc_chain[2];
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      left_raw  <= 16'sh0000;
      right_raw <= 16'sh0000;
      strobe_d  <= 1'b0;
    end else begin
      strobe_d <= sample_strobe;
      if (sample_strobe) begin
        if (cc_level == m2.chan_clock_polarity) begin
          right_raw <= sample_in;
        end else begin
          left_raw <= sample_in;
        end
      end
    end
  end

  always_comb begin
    route_l = left_raw;
    route_r = right_raw;
    if (m2.single_channel_select) begin
      if (m2.channel_pick) begin
        route_l = right_raw;
      end else begin
        route_r = left_raw;
      end
    end
  end

  // x*c/4095 approximated as (p + p/4096)/4096, exact at the end codes
  function automatic logic signed [15:0] scale(input logic signed [15:0] x,
                                               input logic [11:0] c);
    logic signed [28:0] p;
    logic signed [28:0] q;
    p = x * $signed({1'b0, c});
    q = p + (p >>> 12);
    if (c == `COEFF_UNITY) begin
      scale = x;
    end else if (c == `COEFF_SILENT) begin
      scale = 16'sh0000;
    end else if (c == `COEFF_MIN && x <= `QUIET_LEVEL && x >= -(`QUIET_LEVEL)) begin
      scale = 16'sh0000;
    end else begin
      scale = q[27:12];
    end
  endfunction

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      left_out  <= 16'sh0000;
      right_out <= 16'sh0000;
      out_valid <= 1'b0;
    end else begin
      out_valid <= strobe_d;
      if (strobe_d) begin
        left_out  <= scale(route_l, atten_coeff);
        right_out <= scale(route_r, atten_coeff);
      end
    end
  end

  assign apb_take = psel && penable && !pready;

  always_comb begin
    rdata  = 32'h0;
    rd_map = 1'b1;
    case (paddr)
      `REG_CTRL:  rdata = {31'h0, cmd_enable};
      `REG_ATTEN: rdata = {20'h0, atten_coeff};
      `REG_MODE:  rdata = {20'h0, m3, m2};
      `REG_STATE: rdata = {20'h0, boost_mute_gain, dynamic_active, boost_level};
      default:    rd_map = 1'b0;
    endcase
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pready  <= 1'b0;
      prdata  <= 32'h0;
      pslverr <= 1'b0;
    end else begin
      pready  <= apb_take;
      pslverr <= apb_take && !rd_map;
      if (apb_take) begin
        prdata <= pwrite ? 32'h0 : rdata;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cmd_enable <= `CTRL_RESET;
    end else if (psel && penable && pready && pwrite && paddr == `REG_CTRL) begin
      cmd_enable <= pwdata[`CTRL_ENABLE_BIT];
    end
  end

  default clocking chk @(posedge clk); endclocking
  default disable iff (!rst_b);

  atten_store_a: assert property (
    cmd.valid && cmd_enable && !cmd.word[12] |=> atten_coeff == $past(cmd.word[11:0]))
    else $error("attenuator word not stored");
  unity_gain_a: assert property (
    out_valid && $past(atten_coeff) == 12'hfff |-> left_out == $past(route_l))
    else $error("unity code altered the sample");
  silent_gain_a: assert property (
    out_valid && $past(atten_coeff) == 12'h000 |-> left_out == 0 && right_out == 0)
    else $error("zero code did not silence output");
  quiet_floor_a: assert property (
    out_valid && $past(atten_coeff) == 12'h001 && $past(route_r) <= 130
      && $past(route_r) >= -130 |-> right_out == 0)
    else $error("quiet input at minimum gain not zeroed");
  mode2_decode_a: assert property (
    cmd.valid && cmd_enable && cmd.word[12:11] == 2'h2
      |=> ##1 deemph_enable == $past(cmd.word[10], 2))
    else $error("mode 2 word not applied");
  single_channel_select_route_a: assert property (
    out_valid && $past(m2.single_channel_select) |-> left_out == right_out)
    else $error("single channel output differs between sides");
  polarity_map_a: assert property (
    sample_strobe && !cc_level && !m2.chan_clock_polarity |=> right_raw == $past(sample_in))
    else $error("low channel clock data not taken as right");
  dyn_override_a: assert property (
    $past(m3.extra_boost) |-> dynamic_active)
    else $error("extra boost did not force dynamic circuit on");
  mute_falls_a: assert property (
    m3.boost_path_mute && $past(m3.boost_path_mute) |-> boost_mute_gain <= $past(boost_mute_gain))
    else $error("mute gain rose while mute held");
  mute_clear_a: assert property (
    !m3.boost_path_mute |=> boost_mute_gain == 8'hff)
    else $error("mute not removed on clear");
  mode_hold_a: assert property (
    cmd.valid && !cmd.word[12] |=> $stable(m2) && $stable(m3))
    else $error("attenuator word disturbed other settings");

  mode3_seen_c: cover property (cmd.valid && cmd_enable && cmd.word[12:11] == 2'h3);
  mute_done_c: cover property (mute_state == dac_ctrl_pkg::MUTE_HELD);
  single_channel_select_out_c: cover property (out_valid && m2.single_channel_select);
  bus_error_c: cover property (pready && pslverr);

endmodule // audio_dac_serial_control_settings

// file: serial_host.sv
module serial_host #(
  parameter int HALF_CYC = 4
)(
  input  wire logic clk,
  output logic      shift_pin,
  output logic      latch_pin,
  output logic      data_pin
);
  timeunit 1ns;
  timeprecision 1ns;

  initial begin
    shift_pin = 1'b0;
    latch_pin = 1'b0;
    data_pin  = 1'b1;
  end

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clk);
  endtask

  // data settles a half period before each rise; shift idles low between words
  task automatic send_word(input logic [12:0] w);
    @(posedge clk);
    for (int i = 12; i >= 0; i--) begin
      data_pin <= w[i];
      wait_cyc(HALF_CYC);
      shift_pin <= 1'b1;
      wait_cyc(HALF_CYC);
      shift_pin <= 1'b0;
    end
    wait_cyc(HALF_CYC);
    latch_pin <= 1'b1;
    wait_cyc(2 * HALF_CYC);
    latch_pin <= 1'b0;
    // released line shows the inverse so a stale bit cannot pass
    data_pin <= ~w[0];
    wait_cyc(2 * HALF_CYC);
  endtask
endmodule // serial_host

// file: tb.sv
`include "dac_ctrl_map.svh"

module tb;
  timeunit 1ns;
  timeprecision 1ns;

  logic                 clk, rst_b, shift_pin, latch_pin, serial_data_in, channel_clock;
  logic signed [15:0]   sample_in, left_out, right_out;
  logic                 sample_strobe, psel, penable, pwrite, pready, pslverr, out_valid;
  logic [7:0]           paddr, fixed_boost_tenth_db, boost_mute_gain;
  logic [31:0]          pwdata, prdata, attack_cycles, recovery_cycles;
  logic                 deemph_enable, dynamic_active, high_boost, pol;
  logic [5:0]           comp_threshold_db;
  logic [4:0]           comp_ratio_db;
  dac_ctrl_pkg::boost_e boost_level;
  int                   n_mismatch = 0;
  int                   checked = 0;
  // level and fixed boost per {hi, lo, extra}
  int                   lvl [8] = '{0, 0, 1, 2, 2, 4, 3, 5};
  int                   fix [8] = '{0, 0, 106, 0, 152, 0, 152, 0};

  audio_dac_serial_control_settings dut (
    .clk(clk), .rst_b(rst_b), .shift_pin(shift_pin), .latch_pin(latch_pin),
    .serial_data_in(serial_data_in), .channel_clock(channel_clock), .sample_in(sample_in),
    .sample_strobe(sample_strobe), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .left_out(left_out), .right_out(right_out), .out_valid(out_valid),
    .deemph_enable(deemph_enable), .comp_threshold_db(comp_threshold_db),
    .comp_ratio_db(comp_ratio_db), .dynamic_active(dynamic_active),
    .boost_level(boost_level), .high_boost(high_boost),
    .fixed_boost_tenth_db(fixed_boost_tenth_db), .boost_mute_gain(boost_mute_gain),
    .attack_cycles(attack_cycles), .recovery_cycles(recovery_cycles)
  );

  serial_host host (
    .clk(clk), .shift_pin(shift_pin), .latch_pin(latch_pin), .data_pin(serial_data_in)
  );

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic hang();
    n_mismatch++;
    $display("[FAIL] %0t wait ran out", $time);
    complete_run();
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic err);
    int n;
    @(posedge clk);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) hang();
    q = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    logic        e;
    apb(1'b0, a, 32'h0, q, e);
    check({31'h0, e}, 32'h0);
    check(q, exp);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic        e;
    apb(1'b1, a, d, q, e);
  endtask

  // left goes out while the channel clock differs from the polarity bit
  task automatic play(input logic signed [15:0] l, input logic signed [15:0] r,
                      input logic signed [15:0] el, input logic signed [15:0] er);
    int n;
    @(posedge clk);
    channel_clock <= ~pol;
    repeat (6) @(posedge clk);
    sample_in     <= l;
    sample_strobe <= 1'b1;
    @(posedge clk);
    sample_strobe <= 1'b0;
    channel_clock <= pol;
    repeat (6) @(posedge clk);
    sample_in     <= r;
    sample_strobe <= 1'b1;
    @(posedge clk);
    sample_strobe <= 1'b0;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (out_valid !== 1'b1 && n < 10);
    if (out_valid !== 1'b1) hang();
    check(32'(left_out), 32'(el));
    check(32'(right_out), 32'(er));
  endtask

  initial begin
    logic [31:0] q;
    logic        e;
    int          n;
    rst_b = 1'b0;
    channel_clock = 1'b0;
    sample_in = 16'sh0000;
    sample_strobe = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    pol = 1'b0;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    rd_chk(`REG_CTRL, 32'h1);
    rd_chk(`REG_ATTEN, 32'h0);
    rd_chk(`REG_MODE, 32'h0);
    check(32'(comp_threshold_db), 32'd24);
    check(32'(dynamic_active), 32'h1);
    check(32'(boost_mute_gain), 32'hff);
    check(attack_cycles, 32'(`ATTACK_SHORT_US * `CLK_MHZ));
    apb(1'b0, 8'h10, 32'h0, q, e);
    check({31'h0, e}, 32'h1);
    host.send_word(13'h0fff);
    rd_chk(`REG_ATTEN, 32'hfff);
    wr(`REG_ATTEN, 32'h0);
    rd_chk(`REG_ATTEN, 32'hfff);
    play(16'sd1000, -16'sd1000, 16'sd1000, -16'sd1000);
    host.send_word(13'h0001);
    play(16'sd100, -16'sd130, 16'sd0, 16'sd0);
    host.send_word(13'h0000);
    play(16'sd20000, -16'sd20000, 16'sd0, 16'sd0);
    host.send_word(13'h0fff);
    for (int i = 0; i < 6; i++) begin
      host.send_word({2'b10, 6'(6'h1 << i), 5'h00});
      rd_chk(`REG_MODE, 32'(6'h1 << i));
      check(32'(deemph_enable), 32'(i == 5));
      check(32'(comp_threshold_db), (i == 1) ? 32'd36 : 32'd24);
      check(32'(comp_ratio_db), (i == 1) ? 32'd18 : 32'd12);
      check(32'(dynamic_active), 32'(i != 0));
    end
    host.send_word({2'b10, 6'b010000, 5'h00});
    play(16'sd111, 16'sd222, 16'sd111, 16'sd111);
    host.send_word({2'b10, 6'b011000, 5'h00});
    play(16'sd111, 16'sd222, 16'sd222, 16'sd222);
    host.send_word({2'b10, 6'b001000, 5'h00});
    play(16'sd5, 16'sd6, 16'sd5, 16'sd6);
    host.send_word({2'b10, 6'b000100, 5'h00});
    pol = 1'b1;
    play(16'sd333, 16'sd444, 16'sd333, 16'sd444);
    host.send_word({2'b10, 6'b000001, 5'h00});
    for (int k = 0; k < 8; k++) begin
      host.send_word({2'b11, 3'(k), 3'b000, 5'h00});
      check(32'(boost_level), 32'(lvl[k]));
      check(32'(high_boost), 32'(k >= 6));
      check(32'(dynamic_active), 32'(k % 2));
      check(32'(fixed_boost_tenth_db), 32'(fix[k]));
      rd_chk(`REG_MODE, {20'h0, 3'(k), 9'h001});
      rd_chk(`REG_STATE, {20'h0, 8'hff, 1'(k % 2), 3'(lvl[k])});
    end
    for (int t = 0; t < 4; t++) begin
      host.send_word({2'b11, 4'h0, 2'(t), 5'h00});
      check(attack_cycles, (t >= 2) ? 32'(`ATTACK_LONG_US * `CLK_MHZ)
                                    : 32'(`ATTACK_SHORT_US * `CLK_MHZ));
      check(recovery_cycles, (t % 2) ? 32'(`RECOVERY_LONG_US * `CLK_MHZ)
                                     : 32'(`RECOVERY_SHORT_US * `CLK_MHZ));
    end
    host.send_word({2'b11, 6'b000100, 5'h00});
    // first step of the ramp comes one mute step after the word lands
    n = 0;
    while (boost_mute_gain === 8'hff && n < 400) begin
      @(posedge clk);
      n++;
    end
    if (boost_mute_gain === 8'hff) hang();
    check(32'(boost_mute_gain > 8'h00 && boost_mute_gain < 8'hff), 32'h1);
    n = 0;
    while (boost_mute_gain !== 8'h00 && n < 40000) begin
      @(posedge clk);
      n++;
    end
    if (boost_mute_gain !== 8'h00) hang();
    check(32'(boost_mute_gain), 32'h0);
    check(32'(n >= (`MUTE_TC_US * `CLK_MHZ) / 2), 32'h1);
    host.send_word({2'b11, 6'b000000, 5'h00});
    check(32'(boost_mute_gain), 32'hff);
    wr(`REG_CTRL, 32'h0);
    rd_chk(`REG_CTRL, 32'h0);
    host.send_word({2'b10, 6'b100000, 5'h00});
    rd_chk(`REG_MODE, 32'h1);
    wr(`REG_CTRL, 32'h1);
    host.send_word(13'h0800);
    rd_chk(`REG_MODE, 32'h1);
    rd_chk(`REG_ATTEN, 32'h800);
    complete_run();
  end
endmodule // tb
